// *** rtl/ddrgt_bit_sel.sv ***
// Selects one request address bit as the source of one memory address bit.
`timescale 1ns/100ps
`default_nettype none
module ddrgt_bit_sel #(
	parameter int unsigned BASE = 0
) (
	input  wire logic [31:0] addr,
	input  wire logic [3:0]  sel,
	output logic             bit_out
);
	import ddrgt_pkg::*;

	logic [5:0] src;

	always_comb begin
		src = 6'(BASE) + {2'b00, sel};
		// Bit 31 is never a source, so a smaller memory repeats across the space.
		if (sel != MAP_UNUSED && src <= 6'(SPACE_MSB)) begin
			bit_out = addr[src[4:0]];
		end else begin
			bit_out = 1'b0;
		end
	end
endmodule
`default_nettype wire

// *** rtl/ddrgt_pkg.sv ***
// Shared constants, types and register map of the DDR global timing and address map block.
// -----------------------------------------------------------------------------
// Overview of operation
// - After any read, wait the read-to-write gap before issuing a write.
// - After any write, wait the write-to-read gap before issuing a read.
// - Start driving write data once the write data delay after a write expires.
// - Apply both init delay counts during initialisation; suggested 0x4242 and 0x8.
// - Each row and bank bit, and each column bit above the width-fixed ones, takes one request bit chosen by its field.
// - Source request bit equals the field's fixed base plus its programmed value.
// - The low row field steers row bits 0 to 11 together.
// - Request bits 4:0 give C0-C2 full, C0-C3 half, C0-C4 quarter width.
// - Default map orders row above bank above column.
// - Decode a 2 GB space; upper unused bits ignored, memory mirrors.
// - After reset, load mode register and extended modes 1 to 3 from registers.
// - Wait the mode set delay and mode update delay between mode loads.
// - Writing 0 holds soft reset; writing 1 through the alias releases it.
// -----------------------------------------------------------------------------
package ddrgt_pkg;

	// -------------------------------------------------------------------------
	// Register offsets
	// -------------------------------------------------------------------------
	localparam logic [11:0] OFS_SOFT_RESET_CTRL  = 12'h000;
	localparam logic [11:0] OFS_SOFT_RESET_ALIAS = 12'h004;
	localparam logic [11:0] OFS_TURNAROUND       = 12'h008;
	localparam logic [11:0] OFS_INIT_DELAY_A     = 12'h00C;
	localparam logic [11:0] OFS_INIT_DELAY_B     = 12'h010;
	localparam logic [11:0] OFS_MODE_LOAD_TIMING = 12'h014;
	localparam logic [11:0] OFS_MODE_VALUE_0     = 12'h018;
	localparam logic [11:0] OFS_MODE_VALUE_1     = 12'h01C;
	localparam logic [11:0] OFS_MODE_VALUE_2     = 12'h020;
	localparam logic [11:0] OFS_MODE_VALUE_3     = 12'h024;
	localparam logic [11:0] OFS_BANK_MAP         = 12'h028;
	localparam logic [11:0] OFS_COL_MAP_A        = 12'h02C;
	localparam logic [11:0] OFS_COL_MAP_B        = 12'h030;
	localparam logic [11:0] OFS_COL_MAP_C        = 12'h034;
	localparam logic [11:0] OFS_ROW_MAP_A        = 12'h038;
	localparam logic [11:0] OFS_ROW_MAP_B        = 12'h03C;
	localparam logic [11:0] OFS_BUS_WIDTH        = 12'h040;
	localparam logic [11:0] OFS_STATUS           = 12'h044;

	// -------------------------------------------------------------------------
	// Field positions
	// -------------------------------------------------------------------------
	localparam int unsigned SOFT_RESET_BIT   = 0;
	localparam int unsigned RD2WR_LSB        = 0;
	localparam int unsigned WR2RD_LSB        = 8;
	localparam int unsigned WDELAY_LSB       = 16;
	localparam int unsigned MODE_SET_LSB     = 0;
	localparam int unsigned MODE_UPD_LSB     = 8;
	localparam int unsigned GAP_W            = 8;
	localparam int unsigned WDELAY_W         = 5;
	localparam int unsigned FIELD_W          = 4;
	localparam logic [3:0]  MAP_UNUSED       = 4'hF;

	// -------------------------------------------------------------------------
	// Address map geometry
	// -------------------------------------------------------------------------
	localparam int unsigned ROW_BASE         = 6;
	localparam int unsigned BANK_BASE        = 2;
	localparam int unsigned COL_BASE_ADJ     = 1;
	localparam int unsigned ROW_LOW_BITS     = 12;
	localparam int unsigned SPACE_MSB        = 30;

	// -------------------------------------------------------------------------
	// Reset values
	// -------------------------------------------------------------------------
	localparam logic [31:0] TURNAROUND_RST   = 32'h0004_0404;
	localparam logic [15:0] INIT_DELAY_A_RST = 16'h4242;
	localparam logic [15:0] INIT_DELAY_B_RST = 16'h0008;
	localparam logic [15:0] MODE_TIMING_RST  = 16'h0C04;
	localparam logic [15:0] MODE_VALUE_RST   = 16'h0000;
	localparam logic [11:0] BANK_MAP_RST     = 12'hBBB;
	localparam logic [15:0] COL_MAP_RST      = 16'h3333;
	localparam logic [3:0]  COL_MAP_C_RST    = 4'hF;
	localparam logic [15:0] ROW_MAP_A_RST    = 16'hAAAA;
	localparam logic [3:0]  ROW_MAP_B_RST    = 4'hF;

	typedef enum logic [1:0] {
		DDRGT_WIDTH_FULL    = 2'b00,
		DDRGT_WIDTH_HALF    = 2'b01,
		DDRGT_WIDTH_QUARTER = 2'b10
	} ddrgt_width_e;

	typedef enum logic [2:0] {
		DDRGT_ST_HALT     = 3'b000,
		DDRGT_ST_INIT_A   = 3'b001,
		DDRGT_ST_INIT_B   = 3'b010,
		DDRGT_ST_MODE     = 3'b011,
		DDRGT_ST_MODE_SET = 3'b100,
		DDRGT_ST_MODE_UPD = 3'b101,
		DDRGT_ST_RUN      = 3'b110
	} ddrgt_state_e;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic [31:0] addr;
	} ddrgt_req_s;

	typedef struct packed {
		logic        write;
		logic [15:0] row;
		logic [2:0]  bank;
		logic [11:0] col;
	} ddrgt_cmd_s;

	typedef struct packed {
		logic [1:0]  index;
		logic [15:0] value;
	} ddrgt_mode_cmd_s;

endpackage

// *** rtl/ddrgt_top.sv ***
// DDR global command spacing, address mapping and mode register initialisation.
`timescale 1ns/100ps
`default_nettype none
module ddrgt_top (
	input  wire logic                       core_clk,
	input  wire logic                       rst,
	input  wire logic [11:0]                paddr,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [31:0]                pwdata,
	output logic [31:0]                     prdata,
	output logic                            pready,
	output logic                            pslverr,
	input  wire ddrgt_pkg::ddrgt_req_s      req,
	output logic                            req_ack,
	output logic                            cmd_valid,
	output ddrgt_pkg::ddrgt_cmd_s           cmd,
	output logic                            wdata_start,
	output logic                            mode_cmd_valid,
	output ddrgt_pkg::ddrgt_mode_cmd_s      mode_cmd,
	output logic                            init_done
);
	import ddrgt_pkg::*;

	// -------------------------------------------------------------------------
	// Register file
	// -------------------------------------------------------------------------
	logic              soft_reset_n, next_soft_reset_n;
	logic [31:0]       turnaround, next_turnaround;
	logic [15:0]       init_delay_a, next_init_delay_a;
	logic [15:0]       init_delay_b, next_init_delay_b;
	logic [15:0]       mode_timing, next_mode_timing;
	logic [3:0][15:0]  mode_value, next_mode_value;
	logic [11:0]       bank_map, next_bank_map;
	logic [15:0]       col_map_a, next_col_map_a;
	logic [15:0]       col_map_b, next_col_map_b;
	logic [3:0]        col_map_c, next_col_map_c;
	logic [15:0]       row_map_a, next_row_map_a;
	logic [3:0]        row_map_b, next_row_map_b;
	logic [1:0]        bus_width, next_bus_width;
	logic [31:0]       next_prdata;
	logic              next_pready;
	logic              next_pslverr;
	logic [31:0]       rd_val;
	logic              hit;
	logic              wr_en;
	logic [31:0]       status_word;

	ddrgt_state_e      state, next_state;
	logic [1:0]        mode_idx, next_mode_idx;

	assign wr_en       = psel & penable & pready & pwrite;
	assign status_word = {24'h0, init_done, state, mode_idx, 1'b0, soft_reset_n};

	always_comb begin
		hit = 1'b1;
		case (paddr)
			OFS_SOFT_RESET_CTRL:  rd_val = {31'h0, soft_reset_n};
			OFS_SOFT_RESET_ALIAS: rd_val = {31'h0, soft_reset_n};
			OFS_TURNAROUND:       rd_val = turnaround;
			OFS_INIT_DELAY_A:     rd_val = {16'h0, init_delay_a};
			OFS_INIT_DELAY_B:     rd_val = {16'h0, init_delay_b};
			OFS_MODE_LOAD_TIMING: rd_val = {16'h0, mode_timing};
			OFS_MODE_VALUE_0:     rd_val = {16'h0, mode_value[0]};
			OFS_MODE_VALUE_1:     rd_val = {16'h0, mode_value[1]};
			OFS_MODE_VALUE_2:     rd_val = {16'h0, mode_value[2]};
			OFS_MODE_VALUE_3:     rd_val = {16'h0, mode_value[3]};
			OFS_BANK_MAP:         rd_val = {20'h0, bank_map};
			OFS_COL_MAP_A:        rd_val = {16'h0, col_map_a};
			OFS_COL_MAP_B:        rd_val = {16'h0, col_map_b};
			OFS_COL_MAP_C:        rd_val = {28'h0, col_map_c};
			OFS_ROW_MAP_A:        rd_val = {16'h0, row_map_a};
			OFS_ROW_MAP_B:        rd_val = {28'h0, row_map_b};
			OFS_BUS_WIDTH:        rd_val = {30'h0, bus_width};
			OFS_STATUS:           rd_val = status_word;
			default: begin
				rd_val = 32'h0;
				hit    = 1'b0;
			end
		endcase
	end

	always_comb begin
		// One wait state: pready rises in the second access cycle, from a flop.
		next_pready       = psel & penable & ~pready;
		next_prdata       = pready ? 32'h0 : prdata;
		next_pslverr      = 1'b0;
		next_soft_reset_n = soft_reset_n;
		next_turnaround   = turnaround;
		next_init_delay_a = init_delay_a;
		next_init_delay_b = init_delay_b;
		next_mode_timing  = mode_timing;
		next_mode_value   = mode_value;
		next_bank_map     = bank_map;
		next_col_map_a    = col_map_a;
		next_col_map_b    = col_map_b;
		next_col_map_c    = col_map_c;
		next_row_map_a    = row_map_a;
		next_row_map_b    = row_map_b;
		next_bus_width    = bus_width;
		if (next_pready) begin
			next_prdata  = pwrite ? 32'h0 : rd_val;
			next_pslverr = ~hit;
		end
		if (wr_en) begin
			case (paddr)
				OFS_SOFT_RESET_CTRL: begin
					if (!pwdata[SOFT_RESET_BIT]) begin
						next_soft_reset_n = 1'b0;
					end
				end
				OFS_SOFT_RESET_ALIAS: begin
					if (pwdata[SOFT_RESET_BIT]) begin
						next_soft_reset_n = 1'b1;
					end
				end
				OFS_TURNAROUND:       next_turnaround   = pwdata;
				OFS_INIT_DELAY_A:     next_init_delay_a = pwdata[15:0];
				OFS_INIT_DELAY_B:     next_init_delay_b = pwdata[15:0];
				OFS_MODE_LOAD_TIMING: next_mode_timing  = pwdata[15:0];
				default: begin
				end
			endcase
			// Mode values and maps only move while the controller is held, so an
			// in-flight translation never sees a half-written map.
			if (!soft_reset_n) begin
				case (paddr)
					OFS_MODE_VALUE_0: next_mode_value[0] = pwdata[15:0];
					OFS_MODE_VALUE_1: next_mode_value[1] = pwdata[15:0];
					OFS_MODE_VALUE_2: next_mode_value[2] = pwdata[15:0];
					OFS_MODE_VALUE_3: next_mode_value[3] = pwdata[15:0];
					OFS_BANK_MAP:     next_bank_map      = pwdata[11:0];
					OFS_COL_MAP_A:    next_col_map_a     = pwdata[15:0];
					OFS_COL_MAP_B:    next_col_map_b     = pwdata[15:0];
					OFS_COL_MAP_C:    next_col_map_c     = pwdata[3:0];
					OFS_ROW_MAP_A:    next_row_map_a     = pwdata[15:0];
					OFS_ROW_MAP_B:    next_row_map_b     = pwdata[3:0];
					OFS_BUS_WIDTH:    next_bus_width     = pwdata[1:0];
					default: begin
					end
				endcase
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			prdata       <= 32'h0;
			pready       <= 1'b0;
			pslverr      <= 1'b0;
			soft_reset_n <= 1'b0;
			turnaround   <= TURNAROUND_RST;
			init_delay_a <= INIT_DELAY_A_RST;
			init_delay_b <= INIT_DELAY_B_RST;
			mode_timing  <= MODE_TIMING_RST;
			mode_value   <= {4{MODE_VALUE_RST}};
			bank_map     <= BANK_MAP_RST;
			col_map_a    <= COL_MAP_RST;
			col_map_b    <= COL_MAP_RST;
			col_map_c    <= COL_MAP_C_RST;
			row_map_a    <= ROW_MAP_A_RST;
			row_map_b    <= ROW_MAP_B_RST;
			bus_width    <= DDRGT_WIDTH_FULL;
		end else begin
			prdata       <= next_prdata;
			pready       <= next_pready;
			pslverr      <= next_pslverr;
			soft_reset_n <= next_soft_reset_n;
			turnaround   <= next_turnaround;
			init_delay_a <= next_init_delay_a;
			init_delay_b <= next_init_delay_b;
			mode_timing  <= next_mode_timing;
			mode_value   <= next_mode_value;
			bank_map     <= next_bank_map;
			col_map_a    <= next_col_map_a;
			col_map_b    <= next_col_map_b;
			col_map_c    <= next_col_map_c;
			row_map_a    <= next_row_map_a;
			row_map_b    <= next_row_map_b;
			bus_width    <= next_bus_width;
		end
	end

	// -------------------------------------------------------------------------
	// Address translation
	// -------------------------------------------------------------------------
	logic [35:0] col_fields;
	logic [19:0] row_fields;
	logic [11:3] col_sel_bits;
	logic [15:0] row_bits;
	logic [2:0]  bank_bits;
	logic [11:0] col_bits;

	assign col_fields = {col_map_c, col_map_b, col_map_a};
	assign row_fields = {row_map_b, row_map_a};

	for (genvar k = 3; k < 12; k++) begin : g_col
		ddrgt_bit_sel #(.BASE(k - COL_BASE_ADJ)) u_sel (
			.addr    (req.addr),
			.sel     (col_fields[(k - 3) * FIELD_W +: FIELD_W]),
			.bit_out (col_sel_bits[k])
		);
	end

	for (genvar k = 0; k < 16; k++) begin : g_row
		if (k < ROW_LOW_BITS) begin : g_low
			ddrgt_bit_sel #(.BASE(ROW_BASE + k)) u_sel (
				.addr    (req.addr),
				.sel     (row_fields[FIELD_W - 1:0]),
				.bit_out (row_bits[k])
			);
		end else begin : g_high
			ddrgt_bit_sel #(.BASE(ROW_BASE + k)) u_sel (
				.addr    (req.addr),
				.sel     (row_fields[(k - 11) * FIELD_W +: FIELD_W]),
				.bit_out (row_bits[k])
			);
		end
	end

	for (genvar k = 0; k < 3; k++) begin : g_bank
		ddrgt_bit_sel #(.BASE(BANK_BASE + k)) u_sel (
			.addr    (req.addr),
			.sel     (bank_map[k * FIELD_W +: FIELD_W]),
			.bit_out (bank_bits[k])
		);
	end

	always_comb begin
		col_bits = {col_sel_bits, 3'b000};
		case (bus_width)
			DDRGT_WIDTH_HALF:    col_bits[3:0] = req.addr[4:1];
			DDRGT_WIDTH_QUARTER: col_bits[4:0] = req.addr[4:0];
			default:             col_bits[2:0] = req.addr[4:2];
		endcase
	end

	// -------------------------------------------------------------------------
	// Initialisation and command scheduling
	// -------------------------------------------------------------------------
	logic [15:0]        wait_cnt, next_wait_cnt;
	logic [GAP_W-1:0]   rd2wr_cnt, next_rd2wr_cnt;
	logic [GAP_W-1:0]   wr2rd_cnt, next_wr2rd_cnt;
	logic [31:0]        wdata_pipe, next_wdata_pipe;
	logic               next_req_ack;
	logic               next_cmd_valid;
	ddrgt_cmd_s         next_cmd;
	logic               next_wdata_start;
	logic               next_mode_cmd_valid;
	ddrgt_mode_cmd_s    next_mode_cmd;
	logic               next_init_done;
	logic               blocked;
	logic               issue;
	logic [GAP_W-1:0]   rd2wr_gap;
	logic [GAP_W-1:0]   wr2rd_gap;
	logic [WDELAY_W-1:0] wdelay;

	assign rd2wr_gap = turnaround[RD2WR_LSB +: GAP_W];
	assign wr2rd_gap = turnaround[WR2RD_LSB +: GAP_W];
	assign wdelay    = turnaround[WDELAY_LSB +: WDELAY_W];

	// A counter at 1 or 0 means the gap is over by the next edge.
	assign blocked = req.write ? (rd2wr_cnt > 8'h01) : (wr2rd_cnt > 8'h01);
	assign issue   = (state == DDRGT_ST_RUN) && req.valid && !req_ack && !blocked;

	always_comb begin
		next_state          = state;
		next_mode_idx       = mode_idx;
		next_wait_cnt       = (wait_cnt != 16'h0) ? wait_cnt - 16'h1 : 16'h0;
		next_rd2wr_cnt      = (rd2wr_cnt != 8'h0) ? rd2wr_cnt - 8'h1 : 8'h0;
		next_wr2rd_cnt      = (wr2rd_cnt != 8'h0) ? wr2rd_cnt - 8'h1 : 8'h0;
		next_wdata_pipe     = {1'b0, wdata_pipe[31:1]};
		next_req_ack        = issue;
		next_cmd_valid      = issue;
		next_cmd            = cmd;
		next_mode_cmd_valid = 1'b0;
		next_mode_cmd       = mode_cmd;
		case (state)
			DDRGT_ST_HALT: begin
				next_mode_idx = 2'd0;
				next_wait_cnt = init_delay_a;
				next_state    = DDRGT_ST_INIT_A;
			end
			DDRGT_ST_INIT_A: begin
				if (wait_cnt == 16'h0) begin
					next_wait_cnt = init_delay_b;
					next_state    = DDRGT_ST_INIT_B;
				end
			end
			DDRGT_ST_INIT_B: begin
				if (wait_cnt == 16'h0) begin
					next_state = DDRGT_ST_MODE;
				end
			end
			DDRGT_ST_MODE: begin
				next_mode_cmd_valid = 1'b1;
				next_mode_cmd.index = mode_idx;
				next_mode_cmd.value = mode_value[mode_idx];
				next_wait_cnt       = {8'h0, mode_timing[MODE_SET_LSB +: 8]};
				next_state          = DDRGT_ST_MODE_SET;
			end
			DDRGT_ST_MODE_SET: begin
				if (wait_cnt == 16'h0) begin
					next_wait_cnt = {8'h0, mode_timing[MODE_UPD_LSB +: 8]};
					next_state    = DDRGT_ST_MODE_UPD;
				end
			end
			DDRGT_ST_MODE_UPD: begin
				if (wait_cnt == 16'h0) begin
					next_mode_idx = mode_idx + 2'd1;
					next_state    = (mode_idx == 2'd3) ? DDRGT_ST_RUN : DDRGT_ST_MODE;
				end
			end
			DDRGT_ST_RUN: begin
				if (issue) begin
					next_cmd.write = req.write;
					next_cmd.row   = row_bits;
					next_cmd.bank  = bank_bits;
					next_cmd.col   = col_bits;
					if (req.write) begin
						next_wr2rd_cnt  = wr2rd_gap;
						next_wdata_pipe = next_wdata_pipe | (32'h1 << wdelay);
					end else begin
						next_rd2wr_cnt = rd2wr_gap;
					end
				end
			end
			default: begin
				next_state = DDRGT_ST_HALT;
			end
		endcase
		// Soft reset overrides all but the command payloads above and clears all timers.
		if (!soft_reset_n) begin
			next_state          = DDRGT_ST_HALT;
			next_mode_idx       = 2'd0;
			next_wait_cnt       = 16'h0;
			next_rd2wr_cnt      = 8'h0;
			next_wr2rd_cnt      = 8'h0;
			next_wdata_pipe     = 32'h0;
			next_req_ack        = 1'b0;
			next_cmd_valid      = 1'b0;
			next_mode_cmd_valid = 1'b0;
		end
		next_wdata_start = next_wdata_pipe[0];
		next_init_done   = (next_state == DDRGT_ST_RUN);
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state          <= DDRGT_ST_HALT;
			mode_idx       <= 2'd0;
			wait_cnt       <= 16'h0;
			rd2wr_cnt      <= 8'h0;
			wr2rd_cnt      <= 8'h0;
			wdata_pipe     <= 32'h0;
			req_ack        <= 1'b0;
			cmd_valid      <= 1'b0;
			cmd            <= '0;
			wdata_start    <= 1'b0;
			mode_cmd_valid <= 1'b0;
			mode_cmd       <= '0;
			init_done      <= 1'b0;
		end else begin
			state          <= next_state;
			mode_idx       <= next_mode_idx;
			wait_cnt       <= next_wait_cnt;
			rd2wr_cnt      <= next_rd2wr_cnt;
			wr2rd_cnt      <= next_wr2rd_cnt;
			wdata_pipe     <= next_wdata_pipe;
			req_ack        <= next_req_ack;
			cmd_valid      <= next_cmd_valid;
			cmd            <= next_cmd;
			wdata_start    <= next_wdata_start;
			mode_cmd_valid <= next_mode_cmd_valid;
			mode_cmd       <= next_mode_cmd;
			init_done      <= next_init_done;
		end
	end
endmodule
`default_nettype wire

// *** sim/ddrgt_checker.sv ***
// Port-level assertions for the DDR global timing and address map block.
`timescale 1ns/100ps
`default_nettype none
module ddrgt_checker (
	input wire logic                  core_clk,
	input wire logic                  rst,
	input wire logic [11:0]           paddr,
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic                  pwrite,
	input wire logic [31:0]           pwdata,
	input wire logic [31:0]           prdata,
	input wire logic                  pready,
	input wire logic                  pslverr,
	input wire ddrgt_pkg::ddrgt_req_s req,
	input wire logic                  req_ack,
	input wire logic                  cmd_valid,
	input wire ddrgt_pkg::ddrgt_cmd_s cmd,
	input wire logic                  wdata_start,
	input wire logic                  mode_cmd_valid,
	input wire ddrgt_pkg::ddrgt_mode_cmd_s mode_cmd,
	input wire logic                  init_done
);
	import ddrgt_pkg::*;
	logic [7:0]  rd2wr, wr2rd, mset, mupd, since_rd, since_wr, since_mode;
	logic [4:0]  wdl, wd_cnt;
	logic [15:0] ia, ib, since_rel;
	logic [1:0]  mode_idx;
	logic        commit, wd_hit;
	assign commit = psel && penable && pready && pwrite;
	assign wd_hit = wd_cnt == 5'h01 || (cmd_valid && cmd.write && wdl == 5'h00);
	// -------------------------------------------------------------------------
	// Shadow timing values
	// -------------------------------------------------------------------------
	// Copies are snooped from completed writes so the checks follow what software set.
	// One write-data countdown only: each write reloads it, so writes closer than the write data delay are misjudged.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			{wdl, wr2rd, rd2wr} <= TURNAROUND_RST[20:0];
			{mupd, mset} <= MODE_TIMING_RST;
			ia <= INIT_DELAY_A_RST;
			ib <= INIT_DELAY_B_RST;
			{since_rd, since_wr, since_mode} <= '1;
			since_rel <= '1;
			wd_cnt <= '0;
			mode_idx <= '0;
		end else begin
			if (commit && paddr == OFS_TURNAROUND) {wdl, wr2rd, rd2wr} <= pwdata[20:0];
			if (commit && paddr == OFS_MODE_LOAD_TIMING) {mupd, mset} <= pwdata[15:0];
			if (commit && paddr == OFS_INIT_DELAY_A) ia <= pwdata[15:0];
			if (commit && paddr == OFS_INIT_DELAY_B) ib <= pwdata[15:0];
			since_rd <= (cmd_valid && !cmd.write) ? 8'h01 : since_rd + 8'(since_rd != 8'hFF);
			since_wr <= (cmd_valid && cmd.write) ? 8'h01 : since_wr + 8'(since_wr != 8'hFF);
			since_mode <= mode_cmd_valid ? 8'h01 : since_mode + 8'(since_mode != 8'hFF);
			since_rel <= (commit && paddr == OFS_SOFT_RESET_ALIAS && pwdata[0]) ? 16'h0001 :
				since_rel + 16'(since_rel != 16'hFFFF);
			wd_cnt <= (cmd_valid && cmd.write) ? wdl : wd_cnt - 5'(wd_cnt != 5'h00);
			mode_idx <= mode_idx + 2'(mode_cmd_valid);
		end
	end
	// -------------------------------------------------------------------------
	// Properties
	// -------------------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence s_rd_cmd; cmd_valid && !cmd.write; endsequence
	sequence s_wr_cmd; cmd_valid && cmd.write; endsequence
	sequence s_hold_req; commit && paddr == OFS_SOFT_RESET_CTRL && !pwdata[0]; endsequence
	property p_rd2wr; s_wr_cmd |-> since_rd >= rd2wr; endproperty
	property p_wr2rd; s_rd_cmd |-> since_wr >= wr2rd; endproperty
	property p_wdata; wdata_start == wd_hit; endproperty
	property p_init_wait; mode_cmd_valid && mode_idx == 2'h0 |-> since_rel >= ia + ib + 16'h0002; endproperty
	property p_mode_gap; mode_cmd_valid && mode_idx != 2'h0 |-> since_mode >= mset + mupd + 8'h02; endproperty
	property p_mode_order; mode_cmd_valid |-> mode_cmd.index == mode_idx; endproperty
	property p_run_only; cmd_valid || req_ack |-> init_done; endproperty
	property p_soft_hold; s_hold_req |-> ##2 !init_done[*3]; endproperty
	a_rd2wr: assert property (p_rd2wr) else $error("write issued too soon after a read");
	a_wr2rd: assert property (p_wr2rd) else $error("read issued too soon after a write");
	a_wdata: assert property (p_wdata) else $error("write data start at the wrong cycle");
	a_init_wait: assert property (p_init_wait) else $error("first mode load before init delays");
	a_mode_gap: assert property (p_mode_gap) else $error("mode loads too close together");
	a_mode_order: assert property (p_mode_order) else $error("mode load index out of order");
	a_run_only: assert property (p_run_only) else $error("command issued before initialisation");
	a_soft_hold: assert property (p_soft_hold) else $error("soft reset did not stop the controller");
endmodule
bind ddrgt_top ddrgt_checker u_chk (.*);
`default_nettype wire

// *** sim/ddrgt_mem_model.sv ***
// Behavioural memory at the command side: keeps mode values and the last command.
`timescale 1ns/100ps
`default_nettype none
module ddrgt_mem_model (
	input wire logic                       core_clk,
	input wire logic                       rst,
	input wire logic                       cmd_valid,
	input wire ddrgt_pkg::ddrgt_cmd_s      cmd,
	input wire logic                       wdata_start,
	input wire logic                       mode_cmd_valid,
	input wire ddrgt_pkg::ddrgt_mode_cmd_s mode_cmd,
	output logic [3:0][15:0]               mode_reg,
	output ddrgt_pkg::ddrgt_cmd_s          last_cmd,
	output int                             n_wdata
);
	import ddrgt_pkg::*;
	// The model accepts every command at once; spacing is judged by the checker.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			mode_reg <= '0;
			last_cmd <= '0;
			n_wdata <= 0;
		end else begin
			if (mode_cmd_valid) mode_reg[mode_cmd.index] <= mode_cmd.value;
			if (cmd_valid) last_cmd <= cmd;
			if (wdata_start) n_wdata <= n_wdata + 1;
		end
	end
endmodule
`default_nettype wire

// *** sim/tb.sv ***
// Self-checking testbench for the DDR global timing and address map block.
`timescale 1ns/100ps
`default_nettype none
module tb;
	import ddrgt_pkg::*;
	logic            core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, err, hw = 0;
	logic [11:0]     paddr = '0;
	logic [31:0]     pwdata = '0, prdata, rd;
	logic            pready, pslverr, req_ack, cmd_valid, wdata_start, mode_cmd_valid, init_done;
	ddrgt_req_s      req = '0;
	ddrgt_cmd_s      cmd, last;
	ddrgt_mode_cmd_s mode_cmd;
	logic [3:0][15:0] mr;
	int              n_wdata, n_mismatch = 0, tests_run = 0, cyc = 0, n;
	localparam logic [31:0] ADDR_A = 32'hAAAA_5574;
	localparam logic [31:0] ADDR_B = 32'h5555_AAA8;
	always #5 core_clk = ~core_clk;
	ddrgt_top dut (.*);
	ddrgt_mem_model mem (.core_clk, .rst, .cmd_valid, .cmd, .wdata_start, .mode_cmd_valid, .mode_cmd,
		.mode_reg(mr), .last_cmd(last), .n_wdata);
	// -------------------------------------------------------------------------
	// Tasks
	// -------------------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Expected command for the default row, bank, column order with the top column field unused.
	function automatic ddrgt_cmd_s ex(input logic w, input logic [31:0] a);
		return {w, 1'b0, a[30:16], a[15:13], 1'b0, hw ? {a[12:6], a[4:1]} : {a[12:5], a[4:2]}};
	endfunction
	task automatic rq(input logic w, input logic [31:0] a);
		@(posedge core_clk);
		req <= '{valid: 1'b1, write: w, addr: a};
		do @(posedge core_clk); while (req_ack !== 1'b1);
		req.valid <= 1'b0;
		#1 chk("cmd", last, ex(w, a));
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_mismatch++;
			stop_test;
		end
	end
	// -------------------------------------------------------------------------
	// Main sequence
	// -------------------------------------------------------------------------
	initial begin
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		apb(0, OFS_TURNAROUND, 0); chk("turnaround", rd, 32'h0004_0404);
		apb(0, OFS_INIT_DELAY_A, 0); chk("init_a", rd, 32'h0000_4242);
		apb(0, OFS_INIT_DELAY_B, 0); chk("init_b", rd, 32'h0000_0008);
		apb(0, 12'hFFC, 0); chk("slverr", err, 1);
		$display("reset value test done");
		apb(1, OFS_INIT_DELAY_A, 4); apb(1, OFS_INIT_DELAY_B, 4);
		apb(1, OFS_MODE_LOAD_TIMING, 32'h0000_0302);
		apb(1, OFS_TURNAROUND, 32'h0003_0506);
		apb(1, OFS_COL_MAP_C, 32'h0000_000F);
		for (int i = 0; i < 4; i++) apb(1, OFS_MODE_VALUE_0 + 12'(4 * i), 32'h0000_A5C0 + i);
		apb(0, OFS_COL_MAP_C, 0); chk("map_c", rd, 32'h0000_000F);
		apb(1, OFS_SOFT_RESET_CTRL, 1);
		repeat (60) @(posedge core_clk);
		chk("held", init_done, 0);
		apb(1, OFS_SOFT_RESET_ALIAS, 1);
		n = 0;
		while (init_done !== 1'b1 && n < 300) begin @(posedge core_clk); n++; end
		chk("released", init_done, 1);
		for (int i = 0; i < 4; i++) chk("mode", mr[i], 32'h0000_A5C0 + i);
		$display("initialisation test done");
		rq(0, ADDR_A);
		rq(1, ADDR_B);
		rq(0, ADDR_A ^ 32'h8000_0000);
		rq(1, ADDR_B);
		repeat (8) @(posedge core_clk);
		chk("wdata", n_wdata, 2);
		$display("traffic test done");
		apb(1, OFS_COL_MAP_A, 32'h0000_1111);
		apb(0, OFS_COL_MAP_A, 0); chk("map_a", rd, 32'h0000_3333);
		apb(1, OFS_SOFT_RESET_CTRL, 0);
		repeat (3) @(posedge core_clk);
		chk("halted", init_done, 0);
		hw = 1'b1;
		apb(1, OFS_BUS_WIDTH, 1); apb(1, OFS_SOFT_RESET_ALIAS, 1);
		rq(0, ADDR_B);
		$display("soft reset test done");
		stop_test;
	end
endmodule
`default_nettype wire
